// file: srcf_pkg.sv
// Shared constants and helpers for the secure remote command frame link
package srcf_pkg;

    // ------------------------------------------------------------
    // Frame constants
    // ------------------------------------------------------------
    localparam logic [7:0] START_DELIM = 8'h7e;
    localparam logic [7:0] TYPE_PLAIN = 8'h17;
    localparam logic [7:0] TYPE_SECURE = 8'h18;
    localparam logic [7:0] RESP_TYPE = 8'h97;
    localparam logic [7:0] CSUM_BASE = 8'hff;
    localparam logic [7:0] RSV_HI = 8'hff;
    localparam logic [7:0] RSV_LO = 8'hfe;
    localparam logic [7:0] PW_ZERO_CHAR = 8'h30;
    localparam logic [7:0] PW_ZERO_LEN = 8'h01;
    localparam logic [15:0] APPLY_CMD_NAME = 16'h4143;
    localparam logic [15:0] FIXED_LEN = 16'h000f;
    localparam int OPT_APPLY_BIT = 1;
    localparam int PW_MAX = 16;
    localparam int PARAM_MAX = 8;
    localparam logic [7:0] DEST_LAST = 8'h07;
    localparam logic [7:0] PAIR_LAST = 8'h01;

    // ------------------------------------------------------------
    // Verdict codes
    // ------------------------------------------------------------
    localparam logic [2:0] RJ_NONE = 3'h0;
    localparam logic [2:0] RJ_CSUM = 3'h1;
    localparam logic [2:0] RJ_SHORT = 3'h2;
    localparam logic [2:0] RJ_LOCKED = 3'h3;
    localparam logic [2:0] RJ_PW = 3'h4;
    localparam logic [2:0] RJ_ENC = 3'h5;
    localparam logic [2:0] RJ_PEER = 3'h6;
    localparam logic [2:0] RJ_LONG = 3'h7;

    // ------------------------------------------------------------
    // Host register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_HDR = 8'h04;
    localparam logic [7:0] REG_DEST_HI = 8'h08;
    localparam logic [7:0] REG_DEST_LO = 8'h0c;
    localparam logic [7:0] REG_PW0 = 8'h10;
    localparam logic [7:0] REG_PW1 = 8'h14;
    localparam logic [7:0] REG_COUNTS = 8'h18;
    localparam logic [7:0] REG_PARAM = 8'h1c;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SECURE_BIT = 1;
    localparam int CTRL_BUSY_BIT = 2;
    localparam logic [3:0] HOST_PW_MAX = 4'h8;
    localparam logic [2:0] HOST_PARAM_MAX = 3'h4;

    function automatic logic [7:0] csum_of(input logic [7:0] s);
        return CSUM_BASE - s;
    endfunction

    function automatic logic [7:0] pick_byte(input logic [63:0] v, input logic [2:0] i);
        return v[{i, 3'b000} +: 8];
    endfunction

endpackage

// file: srcf_link_if.sv
// Byte stream link between the host end and the device end
`timescale 1ns/1ps
interface srcf_link_if;
    logic byte_valid;
    logic [7:0] byte_data;

    modport host (
        output byte_valid,
        output byte_data
    );

    modport dev (
        input byte_valid,
        input byte_data
    );
endinterface

// file: srcf_sum.sv
// Running 8-bit byte sum used for the frame checksum
`timescale 1ns/1ps
module srcf_sum (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clr,
    input wire logic add,
    input wire logic [7:0] data,
    // Result
    output logic [7:0] sum
);
    logic [7:0] sum_q;

    assign sum = sum_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_q <= 8'h00;
        end else if (clr) begin
            sum_q <= 8'h00;
        end else if (add) begin
            sum_q <= sum_q + data;
        end
    end
endmodule

// file: srcf_dev_end.sv
// Device end: parses and polices secure and plain remote command frames
// Behaviour
// - type 0x18 at offset 3 marks secure
// - offset 4 frame id captured, output on frame_id
// - secure only: offset 5 password count, bytes follow
// - eight-byte destination, most significant first
// - option bit 1 set: apply immediately
// - bit 1 clear: hold until apply command
// - command name is two ASCII characters
// - parameters present write, absent query
// - host sends numeric parameters as binary
// - password set: reject plain 0x17 requests
// - password set: need match and encryption
// - password set: sender must have password
// - no password: plain requests accepted
// - no password: ASCII zero password accepted
// - frame starts with start delimiter byte
// - two-byte length, high byte first
// - checksum is 0xff minus byte sum
`timescale 1ns/1ps
module srcf_dev_end (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Frame link
    srcf_link_if.dev link,
    // Local configuration
    input wire logic [7:0] pw_len_cfg,
    input wire logic [srcf_pkg::PW_MAX*8-1:0] pw_cfg,
    input wire logic enc_enable,
    input wire logic peer_pw_set,
    // Verdict
    output logic cmd_valid,
    output logic cmd_reject,
    output logic [2:0] reject_code,
    output logic is_write,
    output logic apply_now,
    output logic apply_req,
    output logic pending,
    // Parsed fields
    output logic [7:0] frame_type,
    output logic [7:0] frame_id,
    output logic [63:0] dest_addr,
    output logic [7:0] options,
    output logic [15:0] cmd_name,
    output logic [63:0] param,
    output logic [3:0] param_cnt
);
    // ------------------------------------------------------------
    // Parser state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE, S_LENH, S_LENL, S_TYPE, S_ID, S_PWLEN, S_PW, S_DEST,
        S_RSV, S_OPT, S_CMD, S_PARAM, S_SKIP, S_CSUM
    } srcf_dev_st_t;

    srcf_dev_st_t st_q, st_d, nxt;
    logic in_v;
    logic [7:0] b;
    logic [15:0] rem_q;
    logic [7:0] len_hi_q, cnt_q, pw_len_q, type_q, id_q, opt_q;
    logic [63:0] dest_q, param_q;
    logic [15:0] cmd_q;
    logic [3:0] param_cnt_q;
    logic pw_ok_q, zero_ok_q, cmd_done_q, long_q;
    logic cmd_valid_q, cmd_reject_q, is_write_q, apply_now_q, apply_req_q, pending_q;
    logic [2:0] reject_code_q;
    logic [7:0] sum;
    logic data_st, last, sec, known, pw_byte_ok, cs_ok, pw_set, done_st, accept, is_apply;
    logic [2:0] code;

    assign in_v = link.byte_valid;
    assign b = link.byte_data;
    assign data_st = !(st_q inside {S_IDLE, S_LENH, S_LENL, S_CSUM});
    assign last = rem_q == 16'h0001;
    assign sec = type_q == srcf_pkg::TYPE_SECURE;
    assign known = sec || type_q == srcf_pkg::TYPE_PLAIN;
    assign pw_byte_ok = (cnt_q < 8'(srcf_pkg::PW_MAX)) && (b == pw_cfg[{cnt_q[3:0], 3'b000} +: 8]);
    assign cs_ok = b == srcf_pkg::csum_of(sum);
    assign pw_set = pw_len_cfg != 8'h00;
    assign done_st = in_v && st_q == S_CSUM && known;
    assign accept = done_st && code == srcf_pkg::RJ_NONE;
    assign is_apply = cmd_q == srcf_pkg::APPLY_CMD_NAME && param_cnt_q == 4'h0;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt = st_q;
        unique case (st_q)
            S_IDLE: nxt = (b == srcf_pkg::START_DELIM) ? S_LENH : S_IDLE;
            S_LENH: nxt = S_LENL;
            S_LENL: nxt = ({len_hi_q, b} == 16'h0000) ? S_CSUM : S_TYPE;
            S_TYPE: nxt = (b == srcf_pkg::TYPE_PLAIN || b == srcf_pkg::TYPE_SECURE) ? S_ID : S_SKIP;
            S_ID: nxt = sec ? S_PWLEN : S_DEST;
            S_PWLEN: nxt = (b == 8'h00) ? S_DEST : S_PW;
            S_PW: nxt = (cnt_q == pw_len_q - 8'h01) ? S_DEST : S_PW;
            S_DEST: nxt = (cnt_q == srcf_pkg::DEST_LAST) ? S_RSV : S_DEST;
            S_RSV: nxt = (cnt_q == srcf_pkg::PAIR_LAST) ? S_OPT : S_RSV;
            S_OPT: nxt = S_CMD;
            S_CMD: nxt = (cnt_q == srcf_pkg::PAIR_LAST) ? S_PARAM : S_CMD;
            S_PARAM: nxt = S_PARAM;
            S_SKIP: nxt = S_SKIP;
            S_CSUM: nxt = S_IDLE;
        endcase
        st_d = st_q;
        if (in_v) begin
            st_d = (data_st && last) ? S_CSUM : nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
            cnt_q <= 8'h00;
            rem_q <= 16'h0000;
        end else if (in_v) begin
            st_q <= st_d;
            cnt_q <= (st_d != st_q) ? 8'h00 : cnt_q + 8'h01;
            if (st_q == S_LENL) begin
                rem_q <= {len_hi_q, b};
            end else if (data_st) begin
                rem_q <= rem_q - 16'h0001;
            end
        end
    end

    srcf_sum u_sum (
        .pclk(pclk),
        .presetn(presetn),
        .clr(in_v && st_q == S_LENL),
        .add(in_v && data_st),
        .data(b),
        .sum(sum)
    );

    // ------------------------------------------------------------
    // Field capture
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_hi_q <= 8'h00;
            type_q <= 8'h00;
            id_q <= 8'h00;
            pw_len_q <= 8'h00;
            pw_ok_q <= 1'b0;
            zero_ok_q <= 1'b0;
            dest_q <= 64'h0;
            opt_q <= 8'h00;
            cmd_q <= 16'h0000;
            cmd_done_q <= 1'b0;
            param_q <= 64'h0;
            param_cnt_q <= 4'h0;
            long_q <= 1'b0;
        end else if (in_v) begin
            case (st_q)
                S_LENH: len_hi_q <= b;
                S_LENL: begin
                    type_q <= 8'h00;
                    cmd_done_q <= 1'b0;
                    long_q <= 1'b0;
                    param_cnt_q <= 4'h0;
                    param_q <= 64'h0;
                end
                S_TYPE: type_q <= b;
                S_ID: id_q <= b;
                S_PWLEN: begin
                    pw_len_q <= b;
                    pw_ok_q <= b == pw_len_cfg;
                    zero_ok_q <= b == srcf_pkg::PW_ZERO_LEN;
                end
                S_PW: begin
                    pw_ok_q <= pw_ok_q && pw_byte_ok;
                    zero_ok_q <= zero_ok_q && b == srcf_pkg::PW_ZERO_CHAR;
                end
                S_DEST: dest_q <= {dest_q[55:0], b};
                S_OPT: opt_q <= b;
                S_CMD: begin
                    cmd_q <= {cmd_q[7:0], b};
                    cmd_done_q <= cnt_q == srcf_pkg::PAIR_LAST;
                end
                S_PARAM: begin
                    if (param_cnt_q < 4'(srcf_pkg::PARAM_MAX)) begin
                        param_q <= {param_q[55:0], b};
                        param_cnt_q <= param_cnt_q + 4'h1;
                    end else begin
                        long_q <= 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checksum, length and password policy verdict
    // ------------------------------------------------------------
    always_comb begin
        code = srcf_pkg::RJ_NONE;
        if (!cs_ok) begin
            code = srcf_pkg::RJ_CSUM;
        end else if (!cmd_done_q) begin
            code = srcf_pkg::RJ_SHORT;
        end else if (long_q) begin
            code = srcf_pkg::RJ_LONG;
        end else if (!sec) begin
            if (pw_set) begin
                code = srcf_pkg::RJ_LOCKED;
            end
        end else if (pw_set) begin
            if (!pw_ok_q) begin
                code = srcf_pkg::RJ_PW;
            end else if (!enc_enable) begin
                code = srcf_pkg::RJ_ENC;
            end else if (!peer_pw_set) begin
                code = srcf_pkg::RJ_PEER;
            end
        end else if (!zero_ok_q) begin
            code = srcf_pkg::RJ_PW;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_valid_q <= 1'b0;
            cmd_reject_q <= 1'b0;
            reject_code_q <= srcf_pkg::RJ_NONE;
            is_write_q <= 1'b0;
            apply_now_q <= 1'b0;
            apply_req_q <= 1'b0;
            pending_q <= 1'b0;
        end else begin
            cmd_valid_q <= accept;
            cmd_reject_q <= done_st && code != srcf_pkg::RJ_NONE;
            apply_req_q <= accept && is_apply;
            if (done_st) begin
                reject_code_q <= code;
                is_write_q <= param_cnt_q != 4'h0;
                apply_now_q <= opt_q[srcf_pkg::OPT_APPLY_BIT];
            end
            if (accept && is_apply) begin
                pending_q <= 1'b0;
            end else if (accept && param_cnt_q != 4'h0 && !opt_q[srcf_pkg::OPT_APPLY_BIT]) begin
                pending_q <= 1'b1;
            end
        end
    end

    assign cmd_valid = cmd_valid_q;
    assign cmd_reject = cmd_reject_q;
    assign reject_code = reject_code_q;
    assign is_write = is_write_q;
    assign apply_now = apply_now_q;
    assign apply_req = apply_req_q;
    assign pending = pending_q;
    assign frame_type = type_q;
    assign frame_id = id_q;
    assign dest_addr = dest_q;
    assign options = opt_q;
    assign cmd_name = cmd_q;
    assign param = param_q;
    assign param_cnt = param_cnt_q;
endmodule

// file: srcf_host_end.sv
// Host end: APB-programmed sender of remote command request frames
`timescale 1ns/1ps
module srcf_host_end (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Frame link
    srcf_link_if.host link
);
    typedef enum logic [3:0] {
        H_IDLE, H_DELIM, H_LENH, H_LENL, H_TYPE, H_ID, H_PWLEN, H_PW,
        H_DEST, H_RSV, H_OPT, H_CMD, H_PARAM, H_CSUM
    } srcf_host_st_t;

    srcf_host_st_t st_q, nxt;
    logic [7:0] cnt_q, byte_d, byte_q, sum;
    logic [31:0] hdr_q, dest_hi_q, dest_lo_q, pw0_q, pw1_q, param_q, rd_mux, prdata_q;
    logic [3:0] pwl_q, pwl_w;
    logic [2:0] pc_q, pc_w;
    logic [15:0] frames_q, len;
    logic secure_q, valid_q, pready_q, pslverr_q;
    logic access, take, hit, wr, start, data_st;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign access = psel && penable;
    assign take = access && pready_q;
    assign hit = paddr[1:0] == 2'b00 && paddr <= srcf_pkg::REG_PARAM;
    assign wr = take && pwrite && hit;
    assign start = wr && paddr == srcf_pkg::REG_CTRL && pwdata[srcf_pkg::CTRL_START_BIT]
        && st_q == H_IDLE;
    assign pwl_w = (pwdata[3:0] > srcf_pkg::HOST_PW_MAX) ? srcf_pkg::HOST_PW_MAX : pwdata[3:0];
    assign pc_w = (pwdata[10:8] > srcf_pkg::HOST_PARAM_MAX) ? srcf_pkg::HOST_PARAM_MAX
        : pwdata[10:8];

    always_comb begin
        unique case (paddr)
            srcf_pkg::REG_CTRL: rd_mux = {frames_q, 13'h0, st_q != H_IDLE, secure_q, 1'b0};
            srcf_pkg::REG_HDR: rd_mux = hdr_q;
            srcf_pkg::REG_DEST_HI: rd_mux = dest_hi_q;
            srcf_pkg::REG_DEST_LO: rd_mux = dest_lo_q;
            srcf_pkg::REG_PW0: rd_mux = pw0_q;
            srcf_pkg::REG_PW1: rd_mux = pw1_q;
            srcf_pkg::REG_COUNTS: rd_mux = {21'h0, pc_q, 4'h0, pwl_q};
            srcf_pkg::REG_PARAM: rd_mux = param_q;
            default: rd_mux = 32'h0;
        endcase
    end

    // One wait state lets read data come from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= access && !pready_q;
            if (access && !pready_q) begin
                prdata_q <= pwrite ? 32'h0 : rd_mux;
                pslverr_q <= !hit;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secure_q <= 1'b0;
            hdr_q <= 32'h0;
            dest_hi_q <= 32'h0;
            dest_lo_q <= 32'h0;
            pw0_q <= 32'h0;
            pw1_q <= 32'h0;
            pwl_q <= 4'h0;
            pc_q <= 3'h0;
            param_q <= 32'h0;
        end else if (wr) begin
            // Fields are not frozen, so software must not rewrite them while busy
            unique case (paddr)
                srcf_pkg::REG_CTRL: secure_q <= pwdata[srcf_pkg::CTRL_SECURE_BIT];
                srcf_pkg::REG_HDR: hdr_q <= pwdata;
                srcf_pkg::REG_DEST_HI: dest_hi_q <= pwdata;
                srcf_pkg::REG_DEST_LO: dest_lo_q <= pwdata;
                srcf_pkg::REG_PW0: pw0_q <= pwdata;
                srcf_pkg::REG_PW1: pw1_q <= pwdata;
                srcf_pkg::REG_COUNTS: begin
                    pwl_q <= pwl_w;
                    pc_q <= pc_w;
                end
                srcf_pkg::REG_PARAM: param_q <= pwdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    // length of data bytes
    assign len = srcf_pkg::FIXED_LEN + {13'h0, pc_q}
        + (secure_q ? {12'h0, pwl_q} + 16'h0001 : 16'h0000);
    assign data_st = !(st_q inside {H_IDLE, H_DELIM, H_LENH, H_LENL, H_CSUM});

    always_comb begin
        nxt = st_q;
        byte_d = 8'h00;
        unique case (st_q)
            H_IDLE: nxt = start ? H_DELIM : H_IDLE;
            H_DELIM: begin
                byte_d = srcf_pkg::START_DELIM;
                nxt = H_LENH;
            end
            H_LENH: begin
                byte_d = len[15:8];
                nxt = H_LENL;
            end
            H_LENL: begin
                byte_d = len[7:0];
                nxt = H_TYPE;
            end
            H_TYPE: begin
                byte_d = secure_q ? srcf_pkg::TYPE_SECURE : srcf_pkg::TYPE_PLAIN;
                nxt = H_ID;
            end
            H_ID: begin
                byte_d = hdr_q[7:0];
                nxt = secure_q ? H_PWLEN : H_DEST;
            end
            H_PWLEN: begin
                byte_d = {4'h0, pwl_q};
                nxt = (pwl_q == 4'h0) ? H_DEST : H_PW;
            end
            H_PW: begin
                byte_d = srcf_pkg::pick_byte({pw1_q, pw0_q}, cnt_q[2:0]);
                nxt = (cnt_q[3:0] == pwl_q - 4'h1) ? H_DEST : H_PW;
            end
            H_DEST: begin
                byte_d = srcf_pkg::pick_byte({dest_hi_q, dest_lo_q}, 3'h7 - cnt_q[2:0]);
                nxt = (cnt_q == srcf_pkg::DEST_LAST) ? H_RSV : H_DEST;
            end
            H_RSV: begin
                byte_d = (cnt_q == 8'h00) ? srcf_pkg::RSV_HI : srcf_pkg::RSV_LO;
                nxt = (cnt_q == srcf_pkg::PAIR_LAST) ? H_OPT : H_RSV;
            end
            H_OPT: begin
                byte_d = hdr_q[15:8];
                nxt = H_CMD;
            end
            H_CMD: begin
                byte_d = (cnt_q == 8'h00) ? hdr_q[31:24] : hdr_q[23:16];
                nxt = (cnt_q != srcf_pkg::PAIR_LAST) ? H_CMD : (pc_q == 3'h0) ? H_CSUM : H_PARAM;
            end
            H_PARAM: begin
                byte_d = srcf_pkg::pick_byte({32'h0, param_q}, 3'h3 - cnt_q[2:0]);
                nxt = (cnt_q[2:0] == pc_q - 3'h1) ? H_CSUM : H_PARAM;
            end
            H_CSUM: begin
                byte_d = srcf_pkg::csum_of(sum);
                nxt = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= H_IDLE;
            cnt_q <= 8'h00;
            valid_q <= 1'b0;
            byte_q <= 8'h00;
            frames_q <= 16'h0000;
        end else begin
            st_q <= nxt;
            cnt_q <= (nxt != st_q) ? 8'h00 : cnt_q + 8'h01;
            valid_q <= st_q != H_IDLE;
            byte_q <= byte_d;
            if (st_q == H_CSUM) begin
                frames_q <= frames_q + 16'h0001;
            end
        end
    end

    srcf_sum u_sum (
        .pclk(pclk),
        .presetn(presetn),
        .clr(st_q == H_LENL),
        .add(data_st),
        .data(byte_d),
        .sum(sum)
    );

    assign link.byte_valid = valid_q;
    assign link.byte_data = byte_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
endmodule

// file: srcf_monitor.sv
// Assertions on the frame link and the device verdicts
`timescale 1ns/1ps
module srcf_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link and device outputs
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic cmd_valid,
    input wire logic cmd_reject,
    input wire logic [2:0] reject_code,
    input wire logic is_write,
    input wire logic apply_now,
    input wire logic apply_req,
    input wire logic pending,
    input wire logic [7:0] options,
    input wire logic [15:0] cmd_name,
    input wire logic [3:0] param_cnt
);
    // ---
    // Checks
    // ---
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_frame_opens: assert property ($rose(byte_valid) |-> byte_data == 8'h7e)
        else $error("no delimiter");
    a_verdict_end: assert property (cmd_valid || cmd_reject |-> $past(byte_valid) && !byte_valid)
        else $error("verdict off frame end");
    a_accept_code: assert property (cmd_valid |-> reject_code == 3'h0 ##1 !cmd_valid)
        else $error("bad accept");
    a_reject_code: assert property (cmd_reject |-> reject_code != 3'h0 && !cmd_valid)
        else $error("bad reject");
    a_apply_now: assert property (cmd_valid |-> apply_now == options[1])
        else $error("apply flag wrong");
    a_write_flag: assert property (cmd_valid |-> is_write == (param_cnt != 4'h0))
        else $error("write flag wrong");
    a_apply_cmd: assert property (apply_req |-> cmd_valid && cmd_name == 16'h4143 ##1 !pending)
        else $error("apply command wrong");
    a_queue_set: assert property (cmd_valid && is_write && !apply_now |=> pending)
        else $error("change not held");
    c_accept: cover property (cmd_valid);
    c_refuse: cover property (cmd_reject);
    c_apply: cover property (apply_req);
endmodule

// file: testbench.sv
// Self-checking bench joining the host end to the device end
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic sec;
        logic [3:0] hl;
        logic [31:0] pw;
        logic [7:0] opt;
        logic [15:0] cmd;
        logic [2:0] pc;
        logic [3:0] cl;
        logic en;
        logic pe;
        logic ok;
        logic [2:0] code;
    } srcf_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, enc = 1'b0, peer = 1'b0;
    logic [3:0] cl = 4'h0;
    logic cmd_valid, cmd_reject, is_write, apply_now, apply_req, pending;
    logic [2:0] reject_code;
    logic [7:0] options, frame_type, frame_id;
    logic [15:0] cmd_name;
    logic [63:0] dest_addr, param;
    logic [3:0] param_cnt;
    int bad_count = 0, check_count = 0;
    // Password held by the device is fixed; rows vary only its length
    srcf_row_t rows [9] = '{
        '{1'b0, 4'h0, 32'h0, 8'h02, 16'h4244, 3'h1, 4'h0, 1'b0, 1'b0, 1'b1, 3'h0},
        '{1'b0, 4'h0, 32'h0, 8'h02, 16'h4244, 3'h1, 4'h4, 1'b1, 1'b1, 1'b0, 3'h3},
        '{1'b1, 4'h4, 32'h6767754e, 8'h00, 16'h4244, 3'h1, 4'h4, 1'b1, 1'b1, 1'b1, 3'h0},
        '{1'b1, 4'h4, 32'h6767754f, 8'h02, 16'h4244, 3'h1, 4'h4, 1'b1, 1'b1, 1'b0, 3'h4},
        '{1'b1, 4'h4, 32'h6767754e, 8'h02, 16'h4244, 3'h1, 4'h4, 1'b0, 1'b1, 1'b0, 3'h5},
        '{1'b1, 4'h4, 32'h6767754e, 8'h02, 16'h4244, 3'h1, 4'h4, 1'b1, 1'b0, 1'b0, 3'h6},
        '{1'b1, 4'h1, 32'h30, 8'h02, 16'h4244, 3'h0, 4'h0, 1'b0, 1'b0, 1'b1, 3'h0},
        '{1'b1, 4'h1, 32'h31, 8'h02, 16'h4244, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0, 3'h4},
        '{1'b0, 4'h0, 32'h0, 8'h00, 16'h4143, 3'h0, 4'h0, 1'b0, 1'b0, 1'b1, 3'h0}};
    srcf_link_if link ();
    always #5 pclk = ~pclk;
    srcf_host_end srcf_host_end_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .link(link));
    srcf_dev_end srcf_dev_end_inst (.pclk, .presetn, .link(link), .pw_len_cfg({4'h0, cl}),
        .pw_cfg({96'h0, 32'h6767754e}), .enc_enable(enc), .peer_pw_set(peer), .cmd_valid,
        .cmd_reject, .reject_code, .is_write, .apply_now, .apply_req, .pending, .frame_type,
        .frame_id, .dest_addr, .options, .cmd_name, .param, .param_cnt);
    srcf_monitor srcf_monitor_inst (.pclk, .presetn, .byte_valid(link.byte_valid),
        .byte_data(link.byte_data), .cmd_valid, .cmd_reject, .reject_code, .is_write,
        .apply_now, .apply_req, .pending, .options, .cmd_name, .param_cnt);
    // ---
    // Tasks
    // ---
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input srcf_row_t r);
        logic [31:0] q;
        logic e;
        cl <= r.cl;
        enc <= r.en;
        peer <= r.pe;
        apb(1'b1, srcf_pkg::REG_HDR, {r.cmd, r.opt, 8'h5a}, q, e);
        apb(1'b1, srcf_pkg::REG_DEST_HI, 32'h0013a200, q, e);
        apb(1'b1, srcf_pkg::REG_DEST_LO, 32'h12345678, q, e);
        apb(1'b1, srcf_pkg::REG_PW0, r.pw, q, e);
        apb(1'b1, srcf_pkg::REG_COUNTS, {21'h0, r.pc, 4'h0, r.hl}, q, e);
        apb(1'b1, srcf_pkg::REG_PARAM, 32'h07000000, q, e);
        apb(1'b1, srcf_pkg::REG_CTRL, {30'h0, r.sec, 1'b1}, q, e);
        for (int i = 0; i < 300; i++) begin
            @(posedge pclk);
            if (cmd_valid === 1'b1 || cmd_reject === 1'b1) break;
        end
        chk("verdict", cmd_valid | cmd_reject, 64'h1);
        chk("accept", cmd_valid, r.ok);
        chk("write", is_write, r.pc != 3'h0);
        chk("apply", apply_now, r.opt[1]);
        chk("code", reject_code, r.code);
        if (r.ok) begin
            chk("dest", dest_addr, 64'h0013a20012345678);
            chk("head", {cmd_name, options, frame_type, frame_id},
                {r.cmd, r.opt, r.sec ? 8'h18 : 8'h17, 8'h5a});
            chk("param", param, (r.pc != 3'h0) ? 64'h7 : 64'h0);
        end
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #100us;
        bad_count++;
        report_and_stop();
    end
    initial begin
        logic [31:0] q;
        logic e;
        repeat (20) @(posedge pclk);
        chk("reset", {cmd_valid, cmd_reject, pending, reject_code}, 64'h0);
        presetn <= 1'b1;
        foreach (rows[i]) send(rows[i]);
        chk("pending", pending, 64'h0);
        // Counts saturate at the host limits
        apb(1'b1, srcf_pkg::REG_COUNTS, 32'h0000070c, q, e);
        apb(1'b0, srcf_pkg::REG_COUNTS, 32'h0, q, e);
        chk("counts", q, 64'h408);
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk("unmapped", {e, q}, 64'h100000000);
        apb(1'b0, srcf_pkg::REG_CTRL, 32'h0, q, e);
        chk("frames", {e, q}, 64'h90000);
        // Mid-run reset must clear verdicts, fields and the frame count
        presetn <= 1'b0;
        @(posedge pclk);
        chk("reset again", {cmd_valid, cmd_reject, is_write, apply_now, param_cnt}, 64'h0);
        presetn <= 1'b1;
        apb(1'b0, srcf_pkg::REG_CTRL, 32'h0, q, e);
        chk("ctrl reset", {e, q}, 64'h0);
        report_and_stop();
    end
endmodule
